// *** verilog/vts_pkg.sv ***
// Purpose: Shared constants and types of the valley timing and fault sequencer
// Assumes: 100 MHz core clock, comparator outputs as active high levels
// Notes: Long counts are copied into top-level parameters
package vts_pkg;

   // ==========================================================
   // Clock and timing
   localparam int CLK_MHZ = 100;
   localparam real T_TIMEOUT_US = 6.5;
   localparam int TIMEOUT_CYC = int'($floor(T_TIMEOUT_US * CLK_MHZ));
   localparam int T_AUX_MS = 90;
   localparam int AUX_CYC = T_AUX_MS * CLK_MHZ * 1000;
   localparam int T_HOLD_S = 4;
   localparam int HOLD_CYC = T_HOLD_S * CLK_MHZ * 1000000;
   localparam int T_LL_MS = 25;
   localparam int LL_CYC = T_LL_MS * CLK_MHZ * 1000;
   localparam int T_LIMIT_BLANKING_WINDOW_NS = 250;
   localparam int LIMIT_BLANKING_WINDOW_CYC = (T_LIMIT_BLANKING_WINDOW_NS * CLK_MHZ + 999) / 1000;
   localparam int T_OVERSHOOT_BLANKING_WINDOW_NS = 80;
   localparam int OVERSHOOT_BLANKING_WINDOW_CYC = (T_OVERSHOOT_BLANKING_WINDOW_NS * CLK_MHZ + 999) / 1000;
   localparam int T_MAXON_US = 36;
   localparam int MAXON_CYC = T_MAXON_US * CLK_MHZ;

   // ==========================================================
   // Valley selection and fault counts
   localparam logic [2:0] OVER_LIMIT = 3'h4;
   localparam logic [3:0] VALLEY_LOW = 4'h1;
   localparam logic [3:0] VALLEY_HIGH = 4'h2;
   localparam int FOLD_SHIFT = 5;
   localparam logic [7:0] FULL_SCALE = 8'hff;

   // ==========================================================
   // Register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_SETPT = 8'h08;
   localparam int CTRL_RUN = 0;
   localparam logic CTRL_RUN_RESET = 1'b1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ON} vts_drv_e;

   typedef struct packed {
      logic valley_below;    // Valley sense below valley threshold
      logic short_above;     // Valley sense above short detect threshold
      logic line_below_ll;   // Line sense below low line level
      logic line_above_hl;   // Line sense above high line level
      logic dim_below_lower; // Dimming input below lower threshold
      logic dim_above_upper; // Dimming input above upper threshold
      logic cs_setpoint;     // Current sense above setpoint
      logic cs_limit;        // Current sense above cycle limit
      logic cs_overshoot;    // Current sense above overshoot threshold
      logic supply_on;       // Supply above turn-on threshold
      logic uvlo;            // Supply undervoltage
   } vts_cmp_s;

endpackage

// *** verilog/vts_sync.sv ***
// Purpose: Two-stage synchroniser for comparator levels
// Assumes: Inputs are asynchronous levels
// Notes: Only the second stage is visible
`timescale 1ns/1ps
`default_nettype none
module vts_sync #(
   parameter int W = 1
) (
   input wire logic clk,          // Core clock
   input wire logic rst,          // Synchronous reset
   input wire logic ce,           // Clock enable
   input wire logic [W-1:0] d,    // Asynchronous levels
   output logic [W-1:0] q         // Synchronised levels
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } vts_sync_s;

   vts_sync_s s;
   vts_sync_s next_s;

   // Shift chain
   always_comb begin
      next_s.s1 = d;
      next_s.s2 = s.s1;
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign q = s.s2;
endmodule
`default_nettype wire

// *** verilog/vts_ahb_regs.sv ***
// Purpose: AHB-Lite slave for control, status and setpoint registers
// Assumes: Single word transfers, zero wait states while ce is high
// Notes: Unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/1ps
`default_nettype none
module vts_ahb_regs (
   input wire logic clk,            // Core clock
   input wire logic rst,            // Synchronous reset
   input wire logic ce,             // Clock enable
   input wire logic hsel,           // Slave select
   input wire logic [31:0] haddr,   // Address
   input wire logic [1:0] htrans,   // Transfer type
   input wire logic hwrite,         // Write
   input wire logic [2:0] hsize,    // Transfer size
   input wire logic [31:0] hwdata,  // Write data
   input wire logic hready,         // Bus ready
   output logic hreadyout,          // Slave ready
   output logic hresp,              // Always OKAY
   output logic [31:0] hrdata,      // Read data
   output logic run,                // Switching enabled
   input wire logic [31:0] status,  // Block status word
   input wire logic [15:0] setpt    // Current setpoint
);
   typedef struct packed {
      logic wr_pend;
      logic [7:0] wr_addr;
      logic run;
      logic [31:0] rdata;
   } vts_regs_s;

   localparam vts_regs_s RESET = '{wr_pend: 1'b0, wr_addr: '0, run: vts_pkg::CTRL_RUN_RESET, rdata: '0};

   vts_regs_s s;
   vts_regs_s next_s;

   // Address phase capture, data phase write, read mux
   always_comb begin
      next_s = s;
      next_s.wr_pend = 1'b0;
      if (s.wr_pend && s.wr_addr == vts_pkg::REG_CTRL) begin
         next_s.run = hwdata[vts_pkg::CTRL_RUN];
      end
      if (hsel && htrans[1] && hready) begin
         next_s.wr_pend = hwrite && hsize == vts_pkg::HSIZE_WORD;
         next_s.wr_addr = haddr[7:0];
         if (!hwrite) begin
            case (haddr[7:0])
               vts_pkg::REG_CTRL: next_s.rdata = 32'(next_s.run);
               vts_pkg::REG_STATUS: next_s.rdata = status;
               vts_pkg::REG_SETPT: next_s.rdata = 32'(setpt);
               default: next_s.rdata = '0;
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= RESET;
      end else if (ce) begin
         s <= next_s;
      end
   end

   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;
   assign run = s.run;
endmodule
`default_nettype wire

// *** verilog/vts_valley_timing_fault_sequencer.sv ***
// Purpose: Valley clock, valley selection, drive gating and fault timers
// Assumes: Comparator outputs arrive asynchronously; dim_code, fold_code
//          and ext_fault come from logic on clk
// Notes: Analog references live outside; only their comparator decisions enter
// Operation
// - Valley sense falling below the 55 mV comparator marks a valley.
// - Valley sense low for 6.5 us emits a time-out pulse.
// - Time-out pulse stands in as a valley clock, also at start-up.
// - Auxiliary short timer clears only when valley sense exceeds 1 V.
// - Short timer reaching 90 ms flags fault and holds off 4 s.
// - Full load switches on first valley low line, second high line.
// - Foldback or dimming counts a selected number of valley clocks.
// - Deeper foldback raises the valley count.
// - Any active fault blocks the next drive pulse.
// - Low line only after line sense below 2.3 V beyond 25 ms.
// - High line at once when line sense exceeds 2.4 V.
// - Drive stays off while dimming input is below 0.7 V.
// - Setpoint zero at lower threshold, full at 2.45 V, linear between.
// - Dimming and foldback factors multiply into the setpoint.
// - Overshoot above 150% limit four periods running starts 4 s hold-off.
// - Overshoot blanking window is much shorter than limit blanking.
// - Cycle current limit trip ends the drive pulse at once.
// - On-time latch is high exactly during switch on-time.
// - After hold-off, resume only once supply exceeds turn-on threshold.
// - Major fault grounds compensation node except under undervoltage.
`timescale 1ns/1ps
`default_nettype none
module vts_valley_timing_fault_sequencer #(
   parameter int AUX_CYCLES = vts_pkg::AUX_CYC,   // Short timer length
   parameter int HOLD_CYCLES = vts_pkg::HOLD_CYC, // Hold-off length
   parameter int LL_CYCLES = vts_pkg::LL_CYC      // Low line blanking
) (
   input wire logic clk,                  // Core clock
   input wire logic rst,                  // Synchronous reset
   input wire logic ce,                   // Clock enable
   input wire vts_pkg::vts_cmp_s cmp_raw, // Comparator levels
   input wire logic [7:0] dim_code,       // Dimming fraction code
   input wire logic [7:0] fold_code,      // Foldback fraction code
   input wire logic fold_active,          // Thermal foldback engaged
   input wire logic ext_fault,            // Other protections tripped
   input wire logic hsel,                 // AHB select
   input wire logic [31:0] haddr,         // AHB address
   input wire logic [1:0] htrans,         // AHB transfer type
   input wire logic hwrite,               // AHB write
   input wire logic [2:0] hsize,          // AHB size
   input wire logic [31:0] hwdata,        // AHB write data
   input wire logic hready,               // AHB ready
   output logic hreadyout,                // AHB slave ready
   output logic hresp,                    // AHB response
   output logic [31:0] hrdata,            // AHB read data
   output logic drv,                      // Gate drive request
   output logic on_latch,                 // On-time latch
   output logic comp_ground,              // Ground compensation node
   output logic aux_short_fault,          // Output short fault
   output logic winding_short_fault,      // Winding short fault
   output logic fault_active,             // Any fault blocks switching
   output logic [15:0] current_setpoint_ref // Scaled current setpoint
);

   // ==========================================================
   // State
   typedef struct packed {
      vts_pkg::vts_drv_e st;
      logic drv;
      logic vprev;
      logic to_pulse;
      logic [9:0] to_cnt;
      logic [31:0] aux_cnt;
      logic aux_fault;
      logic wind_fault;
      logic hold_active;
      logic [31:0] hold_cnt;
      logic comp_gnd;
      logic [31:0] ll_cnt;
      logic low_line;
      logic [3:0] vcnt;
      logic [3:0] need;
      logic [11:0] on_cnt;
      logic over_seen;
      logic [2:0] over_cnt;
      logic [15:0] setpt;
   } vts_core_s;

   vts_core_s s;
   vts_core_s next_s;
   vts_pkg::vts_cmp_s v;
   logic run;
   logic valley_evt;
   logic vclk;
   logic fault_any;
   logic drv_end;
   logic over_hit;
   logic aux_trip;
   logic wind_trip;
   logic [2:0] over_next;
   logic [7:0] dim_f;
   logic [7:0] fold_f;
   logic [3:0] extra;
   logic [31:0] status;

   // ==========================================================
   // Comparator synchronisers
   vts_sync #(
      .W($bits(vts_pkg::vts_cmp_s))
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .d(cmp_raw),
      .q(v)
   );

   // ==========================================================
   // Register slave
   assign status = 32'({s.need, s.over_cnt, s.st, s.drv, s.low_line,
                         s.hold_active, s.wind_fault, s.aux_fault});

   vts_ahb_regs u_regs (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .run(run),
      .status(status),
      .setpt(s.setpt)
   );

   // ==========================================================
   // Valley clock
   assign valley_evt = v.valley_below & ~s.vprev;
   assign vclk = valley_evt | s.to_pulse;
   assign fault_any = s.aux_fault | s.wind_fault | s.hold_active | ext_fault;

   // Dimming and foldback factors
   always_comb begin
      dim_f = dim_code;
      if (v.dim_below_lower) begin
         dim_f = '0;
      end else if (v.dim_above_upper) begin
         dim_f = vts_pkg::FULL_SCALE;
      end
      fold_f = fold_active ? fold_code : vts_pkg::FULL_SCALE;
      extra = 4'((vts_pkg::FULL_SCALE - s.setpt[15:8]) >> vts_pkg::FOLD_SHIFT);
   end

   // ==========================================================
   // Next-state logic
   always_comb begin
      next_s = s;
      drv_end = 1'b0;
      over_hit = 1'b0;
      wind_trip = 1'b0;
      over_next = s.over_cnt;
      next_s.vprev = v.valley_below;
      next_s.to_pulse = 1'b0;
      next_s.comp_gnd = s.hold_active & ~v.uvlo;
      next_s.setpt = dim_f * fold_f;

      // Valley count selection
      if (fold_active || !v.dim_above_upper) begin
         next_s.need = (s.low_line ? vts_pkg::VALLEY_LOW : vts_pkg::VALLEY_HIGH) + extra;
      end else begin
         next_s.need = s.low_line ? vts_pkg::VALLEY_LOW : vts_pkg::VALLEY_HIGH;
      end

      // Drive sequencing
      case (s.st)
         vts_pkg::ST_IDLE: begin
            if (run && !fault_any && !v.dim_below_lower) begin
               next_s.st = vts_pkg::ST_WAIT;
               next_s.vcnt = '0;
            end
         end
         vts_pkg::ST_WAIT: begin
            if (fault_any || v.dim_below_lower || !run) begin
               next_s.st = vts_pkg::ST_IDLE;
            end else if (vclk) begin
               if (s.vcnt + 4'h1 >= s.need) begin
                  next_s.st = vts_pkg::ST_ON;
                  next_s.drv = 1'b1;
                  next_s.on_cnt = '0;
                  next_s.over_seen = 1'b0;
                  next_s.vcnt = '0;
               end else begin
                  next_s.vcnt = s.vcnt + 4'h1;
               end
            end
         end
         vts_pkg::ST_ON: begin
            if (s.on_cnt != 12'(vts_pkg::MAXON_CYC - 1)) begin
               next_s.on_cnt = s.on_cnt + 12'h001;
            end
            // Short overshoot blanking
            over_hit = v.cs_overshoot && s.on_cnt >= 12'(vts_pkg::OVERSHOOT_BLANKING_WINDOW_CYC);
            if (over_hit) begin
               next_s.over_seen = 1'b1;
            end
            // Longer limit blanking, max on-time, dimming and faults
            drv_end = ((v.cs_limit || v.cs_setpoint) && s.on_cnt >= 12'(vts_pkg::LIMIT_BLANKING_WINDOW_CYC))
                      || s.on_cnt == 12'(vts_pkg::MAXON_CYC - 1)
                      || v.dim_below_lower || fault_any;
            if (drv_end) begin
               next_s.drv = 1'b0;
               next_s.st = vts_pkg::ST_WAIT;
               next_s.vcnt = '0;
               over_next = (s.over_seen || over_hit) ? s.over_cnt + 3'h1 : '0;
               next_s.over_cnt = over_next;
               wind_trip = over_next == vts_pkg::OVER_LIMIT;
               if (wind_trip) begin
                  next_s.over_cnt = '0;
               end
            end
         end
         default: begin
            next_s.st = vts_pkg::ST_IDLE;
            next_s.drv = 1'b0;
         end
      endcase

      // Time-out counter
      if (valley_evt || drv_end || !v.valley_below) begin
         next_s.to_cnt = '0;
      end else if (s.to_cnt == 10'(vts_pkg::TIMEOUT_CYC - 1)) begin
         next_s.to_cnt = '0;
         next_s.to_pulse = 1'b1;
      end else begin
         next_s.to_cnt = s.to_cnt + 10'h001;
      end

      // Auxiliary short timer
      aux_trip = !s.hold_active && !v.short_above && s.aux_cnt == 32'(AUX_CYCLES - 1);
      if (v.short_above) begin
         next_s.aux_cnt = '0;
      end else if (s.aux_cnt != 32'(AUX_CYCLES - 1)) begin
         next_s.aux_cnt = s.aux_cnt + 32'h0000_0001;
      end

      // Line range detection
      if (v.line_above_hl) begin
         next_s.low_line = 1'b0;
         next_s.ll_cnt = '0;
      end else if (v.line_below_ll) begin
         if (s.ll_cnt == 32'(LL_CYCLES)) begin
            next_s.low_line = 1'b1;
         end else begin
            next_s.ll_cnt = s.ll_cnt + 32'h0000_0001;
         end
      end else begin
         next_s.ll_cnt = '0;
      end

      // Hold-off; a new trip wins over the release
      if (aux_trip || wind_trip) begin
         next_s.hold_active = 1'b1;
         next_s.hold_cnt = '0;
         next_s.aux_fault = s.aux_fault | aux_trip;
         next_s.wind_fault = s.wind_fault | wind_trip;
      end else if (s.hold_active) begin
         if (s.hold_cnt != 32'(HOLD_CYCLES)) begin
            next_s.hold_cnt = s.hold_cnt + 32'h0000_0001;
         end else if (v.supply_on) begin
            next_s.hold_active = 1'b0;
            next_s.aux_fault = 1'b0;
            next_s.wind_fault = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   assign drv = s.drv;
   assign on_latch = s.drv;
   assign comp_ground = s.comp_gnd;
   assign aux_short_fault = s.aux_fault;
   assign winding_short_fault = s.wind_fault;
   assign fault_active = fault_any;
   assign current_setpoint_ref = s.setpt;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_timeout;
      $rose(s.to_pulse) |-> $past(s.to_cnt) == 10'(vts_pkg::TIMEOUT_CYC - 1);
   endproperty
   a_timeout: assert property (p_timeout) else $error("time-out pulse at wrong count");

   property p_aux_clear;
      (ce && v.short_above) |=> s.aux_cnt == '0;
   endproperty
   a_aux_clear: assert property (p_aux_clear) else $error("short timer not cleared");

   property p_aux_fault;
      $rose(s.aux_fault) |-> $past(s.aux_cnt) == 32'(AUX_CYCLES - 1) && s.hold_active;
   endproperty
   a_aux_fault: assert property (p_aux_fault) else $error("short fault without full timer");

   property p_fault_block;
      (ce && fault_any && s.st != vts_pkg::ST_ON) |=> !s.drv;
   endproperty
   a_fault_block: assert property (p_fault_block) else $error("pulse started under fault");

   property p_low_line;
      $rose(s.low_line) |-> $past(s.ll_cnt) == 32'(LL_CYCLES) && $past(v.line_below_ll);
   endproperty
   a_low_line: assert property (p_low_line) else $error("low line entered early");

   property p_high_line;
      (ce && v.line_above_hl) |=> !s.low_line;
   endproperty
   a_high_line: assert property (p_high_line) else $error("high line not immediate");

   property p_dim_off;
      (ce && v.dim_below_lower) |=> !s.drv && s.setpt == '0;
   endproperty
   a_dim_off: assert property (p_dim_off) else $error("drive on below dim threshold");

   property p_limit_end;
      (ce && s.st == vts_pkg::ST_ON && v.cs_limit && s.on_cnt >= 12'(vts_pkg::LIMIT_BLANKING_WINDOW_CYC)) |=> !s.drv;
   endproperty
   a_limit_end: assert property (p_limit_end) else $error("limit trip did not end pulse");

   property p_wind;
      $rose(s.wind_fault) |-> $past(s.over_cnt) == vts_pkg::OVER_LIMIT - 3'h1;
   endproperty
   a_wind: assert property (p_wind) else $error("winding fault at wrong count");

   property p_release;
      $fell(s.hold_active) |-> $past(s.hold_cnt) == 32'(HOLD_CYCLES) && $past(v.supply_on);
   endproperty
   a_release: assert property (p_release) else $error("hold-off released early");

   property p_comp;
      (ce && s.hold_active && !v.uvlo) |=> s.comp_gnd;
   endproperty
   a_comp: assert property (p_comp) else $error("compensation not grounded");

endmodule
`default_nettype wire

// *** dv/vts_gate_model.sv ***
// Purpose: Comparator and gate stage model at the far side of the sequencer
// Assumes: Ringing period 40 cycles after a 20 cycle demagnetisation plateau
// Notes: Current limit trips 30 or 60 cycles into each pulse
`timescale 1ns/1ps
`default_nettype none
module vts_gate_model (
   input wire logic clk, // Core clock
   input wire logic drv, // Gate drive
   input wire logic slow, // Slow current ramp
   input wire logic damped, // Ringing too damped to see
   input wire logic shorted, // Valley sense grounded
   input wire logic over, // Overshoot every pulse
   output logic valley_below, // Valley comparator
   output logic short_above, // Short detect comparator
   output logic cs_limit, // Limit comparator
   output logic cs_overshoot, // Overshoot comparator
   output int vcount // Valleys since drive end
);
   // ==========================================
   // Time since the last gate edge and valleys seen
   logic drv_q = 1'b0;
   logic gate;
   logic off;
   int t = 0;
   // Unknown gate before reset reads as off, so time never turns unknown
   assign gate = (drv === 1'b1);
   assign off = !(gate | drv_q);
   always @(posedge clk) begin
      drv_q <= gate;
      t <= (gate != drv_q) ? 0 : t + 1;
      vcount <= (gate != drv_q) ? 0 : vcount + int'(off && !damped && t >= 20 && (t - 20) % 40 == 0);
   end
   // Comparator levels, quiet across gate edges
   assign valley_below = off && (shorted || (t >= 20 && (damped || (t - 20) % 40 < 20)));
   assign short_above = off && !shorted && t < 20;
   assign cs_limit = gate && drv_q && t >= (slow ? 60 : 30);
   assign cs_overshoot = over && cs_limit;
endmodule
`default_nettype wire

// *** dv/tb_vts_valley_timing_fault_sequencer.sv ***
// Purpose: Self-checking bench for the valley timing and fault sequencer
// Assumes: Long counts shortened through parameters
// Notes: Dimming and foldback drawn from a fixed seed, line range from the loop index
`timescale 1ns/1ps
`default_nettype none
module tb_vts_valley_timing_fault_sequencer;
   // ==========================================
   // Stimulus, observation and instances
   localparam int AUX = 3000;
   localparam int HOLD = 300;
   localparam int LL = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ll = 1'b0, hl = 1'b1, dlo = 1'b0, dhi = 1'b1, sup = 1'b1, uv = 1'b0, fold = 1'b0, ext = 1'b0;
   logic slow = 1'b0, damped = 1'b0, shorted = 1'b0, over = 1'b0, drv_q = 1'b0, lowline = 1'b0;
   logic vb, sa, csl, cso, hready, hresp, drv, on_latch, comp_ground, aux_f, wind_f, fault_active;
   logic [7:0] dim_code = 8'h00, fold_code = 8'h00;
   logic [1:0] htrans = 2'h0, mode;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   logic [15:0] sp, exp_sp;
   int vcount, vc, n, n0, lim_w = 0, npulse = 0, num_errors = 0, n_compared = 0;
   vts_pkg::vts_cmp_s cmp;
   assign cmp = {vb, sa, ll, hl, dlo, dhi, 1'b0, csl, cso, sup, uv};
   initial forever #5 clk = ~clk;
   vts_valley_timing_fault_sequencer #(.AUX_CYCLES(AUX), .HOLD_CYCLES(HOLD), .LL_CYCLES(LL))
      i_vts_valley_timing_fault_sequencer (.clk(clk), .rst(rst), .ce(1'b1), .cmp_raw(cmp),
      .dim_code(dim_code), .fold_code(fold_code), .fold_active(fold), .ext_fault(ext), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(vts_pkg::HSIZE_WORD), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .drv(drv), .on_latch(on_latch),
      .comp_ground(comp_ground), .aux_short_fault(aux_f), .winding_short_fault(wind_f),
      .fault_active(fault_active), .current_setpoint_ref(sp));
   vts_gate_model i_vts_gate_model (.clk(clk), .drv(drv), .slow(slow), .damped(damped), .shorted(shorted),
      .over(over), .valley_below(vb), .short_above(sa), .cs_limit(csl), .cs_overshoot(cso), .vcount(vcount));

   // ==========================================
   // Expectations, comparison and bus tasks
   function automatic logic [15:0] sp_f(input logic [1:0] m, input logic f, input logic [7:0] dc, input logic [7:0] fc);
      return 16'(m == 2'h2 ? vts_pkg::FULL_SCALE : (m == 2'h0 ? 8'h00 : dc)) * 16'(f ? fc : vts_pkg::FULL_SCALE);
   endfunction
   function automatic logic [3:0] need_f(input logic low, input logic extra, input logic [15:0] s);
      return (low ? vts_pkg::VALLEY_LOW : vts_pkg::VALLEY_HIGH) + (extra ? 4'((8'hff - s[15:8]) >> 5) : 4'h0);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      chk(32'(hresp), 32'h0);
   endtask
   task automatic pulse(input int max);
      int k;
      k = 0;
      do @(posedge clk); while (!(drv === 1'b1 && drv_q !== 1'b1) && ++k < max);
      vc = vcount;
      chk(32'(k < max), 32'h1);
   endtask
   task automatic set_line(input logic low);
      if (low && !lowline) begin
         hl <= 1'b0;
         ll <= 1'b1;
         repeat (LL - 5) @(posedge clk);
         ll <= 1'b0;
         bus(1'b0, 32'h0000_0004, 32'h0);
         chk(32'(rd[3]), 32'h0);
         ll <= 1'b1;
         repeat (LL + 10) @(posedge clk);
      end else if (!low) begin
         ll <= 1'b0;
         hl <= 1'b1;
         repeat (3) @(posedge clk);
      end
      lowline = low;
      bus(1'b0, 32'h0000_0004, 32'h0);
      chk(32'(rd[3]), 32'(low));
   endtask
   task automatic complete_run;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Pulse count, limit reaction and latch copy
   always @(posedge clk) begin
      drv_q <= drv;
      if (drv === 1'b1 && drv_q !== 1'b1) npulse <= npulse + 1;
      lim_w <= (drv === 1'b1 && csl) ? lim_w + 1 : 0;
      chk(32'(lim_w > 4), 32'h0);
      chk(32'(on_latch), 32'(drv));
   end
   // Watchdog
   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      complete_run();
   end

   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(47351));
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 32'h0000_0000, 32'h0);
      chk(rd, 32'h0000_0001);
      bus(1'b0, 32'h0000_000c, 32'h0);
      chk(rd, 32'h0000_0000);
      bus(1'b1, 32'h0000_0000, 32'h0);
      // A pulse launched as run falls is still counted before the baseline
      repeat (2) @(posedge clk);
      n0 = npulse;
      repeat (300) @(posedge clk);
      chk(32'(npulse), 32'(n0));
      bus(1'b1, 32'h0000_0000, 32'h1);
      for (int i = 0; i < 8; i++) begin
         mode = 2'($urandom_range(2));
         fold <= 1'($urandom_range(1));
         slow <= 1'($urandom_range(1));
         dim_code <= 8'($urandom);
         fold_code <= 8'($urandom);
         dlo <= (mode == 2'h0);
         dhi <= (mode == 2'h2);
         set_line(i[1]);
         exp_sp = sp_f(mode, fold, dim_code, fold_code);
         if (mode == 2'h0) begin
            n0 = npulse;
            repeat (300) @(posedge clk);
            chk(32'(npulse), 32'(n0));
         end else begin
            repeat (2) pulse(2000);
            chk(32'(vc), 32'(need_f(lowline, fold || mode != 2'h2, exp_sp)));
         end
         chk(32'(sp), 32'(exp_sp));
      end
      dlo <= 1'b0;
      dhi <= 1'b1;
      fold <= 1'b0;
      // High line: the second valley clock can only be a time-out pulse
      set_line(1'b0);
      damped <= 1'b1;
      repeat (2) pulse(3000);
      damped <= 1'b0;
      over <= 1'b1;
      repeat (3) pulse(2000);
      over <= 1'b0;
      repeat (2) pulse(2000);
      bus(1'b0, 32'h0000_0004, 32'h0);
      chk(32'(rd[9:7] | {2'b00, wind_f}), 32'h0);
      over <= 1'b1;
      sup <= 1'b0;
      n = 0;
      while (wind_f !== 1'b1 && n++ < 2000) @(posedge clk);
      chk(32'(wind_f & fault_active), 32'h1);
      repeat (3) @(posedge clk);
      chk(32'(comp_ground), 32'h1);
      uv <= 1'b1;
      repeat (4) @(posedge clk);
      chk(32'(comp_ground), 32'h0);
      uv <= 1'b0;
      n0 = npulse;
      repeat (HOLD + 50) @(posedge clk);
      chk(32'(wind_f), 32'h1);
      chk(32'(npulse), 32'(n0));
      sup <= 1'b1;
      over <= 1'b0;
      pulse(2000);
      ext <= 1'b1;
      repeat (2) @(posedge clk);
      n0 = npulse;
      chk(32'(fault_active), 32'h1);
      repeat (300) @(posedge clk);
      chk(32'(npulse), 32'(n0));
      ext <= 1'b0;
      pulse(2000);
      shorted <= 1'b1;
      repeat (AUX - 600) @(posedge clk);
      chk(32'(aux_f), 32'h0);
      n = 0;
      while (aux_f !== 1'b1 && n++ < 1000) @(posedge clk);
      chk(32'(aux_f & fault_active), 32'h1);
      complete_run();
   end
endmodule
`default_nettype wire
